/* rtl/phyrs_ctrl.sv */
// reset stretch, sleep and power-down control, strap capture and indicator drive
//
// Contract
// - internal reset held while reset pin low or software reset bit set
// - after reset request ends, internal reset continues a further 25 us
// - pause strap high makes pause part of the advertised abilities
// - sleep pin high allows the low-power sleep state
// - in managed mode the sleep-enable bit overrides the sleep pin
// - each of three indicators shows the condition its selection field picks
// - strap pins sampled at power-up decide forced settings versus auto-negotiation
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module phyrs_ctrl
	import phyrs_pkg::*;
#(
	parameter int STRETCH_CYCLES = STRETCH_CYC
)
(
	// clock and reset
	input  wire logic            CLK,
	input  wire logic            RST,
	// device pins
	input  wire logic            RESET_PIN_N,
	input  wire logic            SLEEP_PIN,
	input  wire logic            POWER_OFF_PIN,
	input  wire logic            PAUSE_PIN,
	input  wire logic [NLED-1:0] INDICATOR_STRAP_I,
	output logic      [NLED-1:0] INDICATOR_STRAP_O,
	output logic      [NLED-1:0] INDICATOR_STRAP_OE_N,
	// register port
	input  wire logic [AW-1:0]   ADDR,
	input  wire logic [DW-1:0]   WDATA,
	input  wire logic            WR_EN,
	input  wire logic            RD_EN,
	output logic      [DW-1:0]   RDATA,
	// link status from the core
	input  wire logic [NSTAT-1:0] STATUS_IN,
	// control outputs
	output logic                 INT_RST,
	output logic                 SLEEP_OK,
	output logic                 PWR_OFF,
	output logic                 PAUSE_ADV,
	output logic                 FORCED_CFG,
	output logic      [NLED-1:0] STRAP_CFG
);
	localparam int CNT_W = $clog2(STRETCH_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STRETCH_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	if (STRETCH_CYCLES < 1) begin : g_bad_stretch
		$error("stretch count must be at least one cycle");
	end

	typedef struct packed {
		phyrs_state_t         state;
		logic [CNT_W-1:0]     cnt;
		logic                 swrst;
		logic                 sleep_en;
		logic                 managed;
		logic [LED_CFG_W-1:0] led_cfg;
		logic                 int_rst;
		logic                 sleep_ok;
		logic                 pwr_off;
		logic                 pause_adv;
		logic                 forced;
		logic [NLED-1:0]      strap;
		logic [NLED-1:0]      led_o;
		logic [NLED-1:0]      led_oe_n;
		logic [DW-1:0]        rdata;
	} phyrs_ctrl_st_t;

	localparam phyrs_ctrl_st_t ST_RST = '{
		state:    ST_HOLD,
		cnt:      '0,
		swrst:    1'b0,
		sleep_en: 1'b0,
		managed:  1'b0,
		led_cfg:  LED_CFG_RST,
		int_rst:  1'b1,
		sleep_ok: 1'b0,
		pwr_off:  1'b0,
		pause_adv: 1'b0,
		forced:   1'b0,
		strap:    STRAP_AUTO,
		led_o:    '0,
		led_oe_n: '1,
		rdata:    '0
	};

	phyrs_ctrl_st_t st_r;
	phyrs_ctrl_st_t st_nxt;
	phyrs_pin_if    pins ();

	assign pins.raw = {INDICATOR_STRAP_I, PAUSE_PIN, POWER_OFF_PIN, SLEEP_PIN, RESET_PIN_N};

	phyrs_sync u_sync (
		.clk  (CLK),
		.rst  (RST),
		.pins (pins)
	);

	// pick one status condition for each indicator
	function automatic logic [NLED-1:0] led_pick(input logic [LED_CFG_W-1:0] cfg, input logic [NSTAT-1:0] stat);
		logic [NLED-1:0] res;
		res = '0;
		for (int i = 0; i < NLED; i++) begin
			res[i] = stat[cfg[i*LED_SEL_W +: LED_SEL_W]];
		end
		return res;
	endfunction

	logic pin_rst_n;
	logic wr_ctrl;
	logic [NLED-1:0] strap_now;

	assign pin_rst_n = pins.sync[PIN_RST_N];
	assign wr_ctrl   = WR_EN && (ADDR == ADR_CTRL);
	assign strap_now = pins.sync[PIN_STRAP +: NLED];

	always_comb begin
		st_nxt = st_r;
		case (st_r.state)
			ST_HOLD: begin
				// software request stays set through the hold and is cleared only when the stretch completes
				st_nxt.cnt = '0;
				if (pin_rst_n) begin
					st_nxt.state = ST_STRETCH;
				end
			end
			ST_STRETCH: begin
				if (!pin_rst_n) begin
					st_nxt.state = ST_HOLD;
				end else if (st_r.cnt == CNT_LAST) begin
					st_nxt.state = ST_RUN;
					st_nxt.swrst = 1'b0;
					// pins are still undriven here, so they read the board straps
					st_nxt.strap = strap_now;
				end else begin
					st_nxt.cnt = st_r.cnt + CNT_ONE;
				end
			end
			ST_RUN: begin
				if (!pin_rst_n || st_r.swrst) begin
					st_nxt.state = ST_HOLD;
				end
			end
			default: begin
				st_nxt.state = ST_HOLD;
			end
		endcase
		st_nxt.int_rst = (st_nxt.state != ST_RUN);
		st_nxt.forced  = (st_r.strap != STRAP_AUTO);

		// a new write wins over the self-clear in the same cycle
		if (wr_ctrl) begin
			st_nxt.swrst    = st_nxt.swrst | WDATA[CTRL_SWRST];
			st_nxt.sleep_en = WDATA[CTRL_SLEEP_EN];
			st_nxt.managed  = WDATA[CTRL_MANAGED];
		end
		if (WR_EN && (ADDR == ADR_LED)) begin
			st_nxt.led_cfg = WDATA[LED_CFG_W-1:0];
		end

		st_nxt.sleep_ok  = st_r.managed ? st_r.sleep_en : pins.sync[PIN_SLEEP];
		st_nxt.pwr_off   = pins.sync[PIN_PWR];
		st_nxt.pause_adv = pins.sync[PIN_PAUSE];

		// indicators stay released during reset so straps can be read
		st_nxt.led_oe_n = st_nxt.int_rst ? '1 : '0;
		st_nxt.led_o    = st_nxt.int_rst ? '0 : led_pick(st_r.led_cfg, STATUS_IN);

		st_nxt.rdata = '0;
		if (RD_EN) begin
			case (ADDR)
				ADR_CTRL: begin
					st_nxt.rdata[CTRL_SWRST]    = st_r.swrst;
					st_nxt.rdata[CTRL_SLEEP_EN] = st_r.sleep_en;
					st_nxt.rdata[CTRL_MANAGED]  = st_r.managed;
				end
				ADR_LED: begin
					st_nxt.rdata[LED_CFG_W-1:0] = st_r.led_cfg;
				end
				ADR_STAT: begin
					st_nxt.rdata[STAT_INT_RST]          = st_r.int_rst;
					st_nxt.rdata[STAT_SLEEP]            = st_r.sleep_ok;
					st_nxt.rdata[STAT_PWR_OFF]          = st_r.pwr_off;
					st_nxt.rdata[STAT_PAUSE]            = st_r.pause_adv;
					st_nxt.rdata[STAT_FORCED]           = st_r.forced;
					st_nxt.rdata[STAT_STRAP +: NLED]    = st_r.strap;
				end
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign INT_RST              = st_r.int_rst;
	assign SLEEP_OK             = st_r.sleep_ok;
	assign PWR_OFF              = st_r.pwr_off;
	assign PAUSE_ADV            = st_r.pause_adv;
	assign FORCED_CFG           = st_r.forced;
	assign STRAP_CFG            = st_r.strap;
	assign INDICATOR_STRAP_O    = st_r.led_o;
	assign INDICATOR_STRAP_OE_N = st_r.led_oe_n;
	assign RDATA                = st_r.rdata;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	chk_pin_holds_reset: assert property (!pin_rst_n |=> INT_RST ##1 INT_RST)
		else $error("reset pin low did not hold internal reset");
	chk_soft_reset_enter: assert property (st_r.state == ST_RUN && st_r.swrst |=> INT_RST)
		else $error("software reset bit did not assert internal reset");
	chk_stretch_length: assert property ($fell(INT_RST) |-> $past(st_r.cnt) == CNT_LAST)
		else $error("internal reset released before the full stretch");
	chk_stretch_step: assert property (st_r.state == ST_STRETCH && pin_rst_n && st_r.cnt != CNT_LAST
		|=> INT_RST && st_r.cnt == $past(st_r.cnt) + CNT_ONE)
		else $error("stretch counter did not advance");
	chk_pause_advert: assert property (##1 PAUSE_ADV == $past(pins.sync[PIN_PAUSE]))
		else $error("pause advertisement does not follow pause strap");
	chk_sleep_pin: assert property (!st_r.managed && pins.sync[PIN_SLEEP] |=> SLEEP_OK)
		else $error("sleep pin high did not allow sleep");
	chk_sleep_override: assert property (st_r.managed |=> SLEEP_OK == $past(st_r.sleep_en))
		else $error("managed mode sleep bit not obeyed");
	chk_power_down: assert property (pins.sync[PIN_PWR] |=> PWR_OFF)
		else $error("power-down pin not obeyed");
	chk_led_select: assert property (st_r.state == ST_RUN && pin_rst_n && !st_r.swrst
		|=> INDICATOR_STRAP_OE_N == '0 && INDICATOR_STRAP_O == $past(led_pick(st_r.led_cfg, STATUS_IN)))
		else $error("indicator does not show the selected condition");
	chk_strap_steady: assert property (!INT_RST && $past(!INT_RST) |-> $stable(STRAP_CFG))
		else $error("strap capture changed outside reset");
	chk_soft_reset_clear: assert property ($fell(INT_RST) && !$past(wr_ctrl) |-> !st_r.swrst)
		else $error("software reset bit did not self-clear");
endmodule

/* rtl/phyrs_pin_if.sv */
// carrier for raw pin levels and their synchronised copies
`timescale 1ns/1ns
interface phyrs_pin_if;
	import phyrs_pkg::*;
	logic [NPIN-1:0] raw;
	logic [NPIN-1:0] sync;
	modport src (output raw, input sync);
	modport syn (input raw, output sync);
endinterface

/* rtl/phyrs_pkg.sv */
// shared constants and types for the transceiver reset, power and strap controller
package phyrs_pkg;
	localparam int CLK_HZ         = 10_000_000;
	localparam int RST_STRETCH_NS = 25000;
	// nominal stretch treated as a least time, so round up
	localparam int STRETCH_CYC    = (RST_STRETCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	localparam int AW = 8;
	localparam int DW = 8;
	localparam logic [AW-1:0] ADR_CTRL = 8'h00;
	localparam logic [AW-1:0] ADR_LED  = 8'h04;
	localparam logic [AW-1:0] ADR_STAT = 8'h08;

	localparam int CTRL_SWRST    = 0;
	localparam int CTRL_SLEEP_EN = 1;
	localparam int CTRL_MANAGED  = 2;

	localparam int NLED      = 3;
	localparam int LED_SEL_W = 2;
	localparam int LED_CFG_W = NLED * LED_SEL_W;
	localparam logic [LED_CFG_W-1:0] LED_CFG_RST = 6'h24;
	localparam int NSTAT     = 4;

	localparam int STAT_INT_RST = 0;
	localparam int STAT_SLEEP   = 1;
	localparam int STAT_PWR_OFF = 2;
	localparam int STAT_PAUSE   = 3;
	localparam int STAT_FORCED  = 4;
	localparam int STAT_STRAP   = 5;

	localparam int NPIN      = 7;
	localparam int PIN_RST_N = 0;
	localparam int PIN_SLEEP = 1;
	localparam int PIN_PWR   = 2;
	localparam int PIN_PAUSE = 3;
	localparam int PIN_STRAP = 4;
	localparam logic [NLED-1:0] STRAP_AUTO = 3'h7;

	typedef enum logic [2:0] {
		ST_HOLD    = 3'h1,
		ST_STRETCH = 3'h2,
		ST_RUN     = 3'h4
	} phyrs_state_t;
endpackage

/* rtl/phyrs_sync.sv */
// two-flop synchroniser for the asynchronous control pins
`timescale 1ns/1ns
module phyrs_sync
	import phyrs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins
	phyrs_pin_if.syn pins
);
	typedef struct packed {
		logic [NPIN-1:0] meta;
		logic [NPIN-1:0] stab;
	} phyrs_sync_st_t;

	phyrs_sync_st_t st_r;
	phyrs_sync_st_t st_nxt;

	// first stage feeds only the second stage
	always_comb begin
		st_nxt      = st_r;
		st_nxt.meta = pins.raw;
		st_nxt.stab = st_r.meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pins.sync = st_r.stab;
endmodule

/* sim/phy_reset_power_strap_ctrl_tb.sv */
// self-checking bench for the reset, power and strap controller
`timescale 1ns/1ns
module phy_reset_power_strap_ctrl_tb;
	import phyrs_pkg::*;
	localparam int SC = 4;
	logic            clk, rst, rst_pin_n, sleep_pin, pwr_pin, pause_pin;
	logic            wr_en, rd_en, int_rst, sleep_ok, pwr_off, pause_adv, forced;
	logic [NLED-1:0] strap, pin_i, led_o, led_oe_n, strap_cfg;
	logic [AW-1:0]   addr;
	logic [DW-1:0]   wdata, rdata;
	logic [3:0]      status;
	int              fail_count, samples_checked, n;

	phyrs_ctrl #(.STRETCH_CYCLES(SC)) dut (.CLK(clk), .RST(rst), .RESET_PIN_N(rst_pin_n),
		.SLEEP_PIN(sleep_pin), .POWER_OFF_PIN(pwr_pin), .PAUSE_PIN(pause_pin),
		.INDICATOR_STRAP_I(pin_i), .INDICATOR_STRAP_O(led_o), .INDICATOR_STRAP_OE_N(led_oe_n),
		.ADDR(addr), .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata),
		.STATUS_IN(status), .INT_RST(int_rst), .SLEEP_OK(sleep_ok), .PWR_OFF(pwr_off),
		.PAUSE_ADV(pause_adv), .FORCED_CFG(forced), .STRAP_CFG(strap_cfg));
	phyrs_board board (.o(led_o), .oe_n(led_oe_n), .strap(strap), .pin(pin_i));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask
	// counts settled cycles until the internal reset drops, bounded
	task automatic wait_run(output int k);
		k = 0;
		while (int_rst !== 1'b0 && k < 100) begin
			cyc(1);
			k++;
		end
		// a stuck reset is a mismatch in itself
		if (int_rst !== 1'b0) begin
			fail_count++;
			$display("unexpected internal reset: expected 0, seen %b", int_rst);
		end
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		summarize();
	end

	initial begin
		rst = 1'b1; rst_pin_n = 1'b1; sleep_pin = 1'b1; pwr_pin = 1'b0; pause_pin = 1'b1;
		strap = 3'h5; addr = 8'h00; wdata = 8'h00; wr_en = 1'b0; rd_en = 1'b0; status = 4'h6;
		fail_count = 0; samples_checked = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wait_run(n);
		// forced flag follows the captured straps one cycle later
		cyc(1);
		chk("outputs", 8'hba, {strap_cfg, forced, pause_adv, pwr_off, sleep_ok, int_rst});
		rd(ADR_STAT, 8'hba, "status");
		chk("led drive", 8'h06, {2'h0, led_oe_n, led_o});
		rd(ADR_CTRL, 8'h00, "ctrl reset");
		rd(ADR_LED, 8'h24, "led reset");
		wr(8'h0c, 8'hff);
		rd(8'h0c, 8'h00, "unmapped");
		@(posedge clk);
		pause_pin <= 1'b0;
		pwr_pin   <= 1'b1;
		cyc(4);
		chk("pause", 8'h00, {7'h0, pause_adv});
		chk("power off", 8'h01, {7'h0, pwr_off});
		@(posedge clk);
		pwr_pin <= 1'b0;
		cyc(4);
		chk("power on", 8'h00, {7'h0, pwr_off});
		// managed mode: the enable bit wins over the pin both ways
		wr(ADR_CTRL, 8'h04);
		cyc(4);
		chk("sleep managed off", 8'h00, {7'h0, sleep_ok});
		wr(ADR_CTRL, 8'h06);
		sleep_pin <= 1'b0;
		cyc(4);
		chk("sleep managed on", 8'h01, {7'h0, sleep_ok});
		wr(ADR_CTRL, 8'h00);
		cyc(4);
		chk("sleep pin low", 8'h00, {7'h0, sleep_ok});
		@(posedge clk);
		sleep_pin <= 1'b1;
		cyc(4);
		chk("sleep pin high", 8'h01, {7'h0, sleep_ok});
		for (int p = 0; p < 2; p++) begin
			@(posedge clk);
			status <= p ? 4'ha : 4'h5;
			for (int s = 0; s < 4; s++) begin
				wr(ADR_LED, {2'h0, s[1:0], s[1:0], s[1:0]});
				cyc(3);
				chk("led select", {5'h0, {3{status[s]}}}, {5'h0, led_o});
			end
		end
		// software reset also recaptures the straps, now all high
		@(posedge clk);
		strap <= 3'h7;
		wr(ADR_CTRL, 8'h01);
		cyc(2);
		chk("sw reset", 8'h0f, {4'h0, led_oe_n, int_rst});
		wait_run(n);
		chk("sw stretch", 8'h01, {7'h0, n >= SC});
		rd(ADR_CTRL, 8'h00, "sw reset self clear");
		chk("auto straps", 8'h07, {4'h0, forced, strap_cfg});
		@(posedge clk);
		rst_pin_n <= 1'b0;
		cyc(4);
		chk("pin reset", 8'h01, {7'h0, int_rst});
		cyc(5);
		@(posedge clk);
		rst_pin_n <= 1'b1;
		wait_run(n);
		chk("pin stretch", 8'h01, {7'h0, n >= SC + 2 && n <= SC + 6});
		summarize();
	end
endmodule

/* sim/phyrs_board.sv */
// board model: strap resistors behind the indicator/strap pins
`timescale 1ns/1ns
module phyrs_board
	import phyrs_pkg::*;
(
	// pin side of the device
	input  wire logic [NLED-1:0] o,
	input  wire logic [NLED-1:0] oe_n,
	// resistor levels fitted on the board
	input  wire logic [NLED-1:0] strap,
	output logic      [NLED-1:0] pin
);
	// a released pin shows its resistor level, never the last value driven
	always_comb begin
		for (int i = 0; i < NLED; i++) begin
			pin[i] = oe_n[i] ? strap[i] : o[i];
		end
	end
endmodule
